// ### logic/ccl_comparator_control.sv
// comparator control logic: enable, result latch, polarity, input muxing, edge event flag
// assumes the analog comparator answers on comparator_raw (1 = negative below positive)
// and that routing selects drive analog switches outside this block
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register addresses.
`default_nettype none
// Summary of operation
// - The comparator runs only while the on bit is set; cleared, it is powered down.
// - The result reads both as a bit of control 0 and as a bit of the mirror register.
// - The result is latched only when two successive samples agree, while the pin output path stays unlatched.
// - Without invert the result is 1 when negative is below positive; invert reverses it.
// - The negative select maps 111 ground, 110 ref buffer 2, 101/100 open, 011..000 pins 3..0.
// - The positive select maps 111 ground, 110 ref buffer 2, 101 converter, 100..010 open, 001/000 pins.
// - Each select holds its field in bits 2:0, bits 7:3 read zero, and resets to zero.
// - The event flag is set on the event, holds until software clears it, else reads 0.
// - The event flag is set only on edges whose kind is enabled in control 1.
module ccl_comparator_control
    import ccl_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic comparator_raw,
    output logic comparator_power,
    output logic [5:0] negative_route,
    output logic [4:0] positive_route,
    output logic pin_result
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic on_bit, invert_bit, pos_edge_en, neg_edge_en;
    logic [2:0] negative_channel_field, positive_channel_field;
    logic sync1, sync2, sync3, latched, event_flag;
    logic next_on_bit, next_invert_bit, next_pos_edge_en, next_neg_edge_en;
    logic [2:0] next_neg_field, next_pos_field;
    logic next_latched, next_event_flag;
    logic aw_held, w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic next_aw_held, next_w_held, next_bvalid, next_rvalid;
    logic [7:0] next_aw_addr;
    logic [31:0] next_w_data, next_rdata;
    logic [3:0] next_w_strb;
    logic [1:0] next_bresp, next_rresp;
    logic do_write, write_ok, rise, fall, event_clear, polar;
    logic [31:0] rd_word;
    logic rd_ok;

    // ----------------------------------------------------------------
    // result path
    // ----------------------------------------------------------------
    // analog output is async to aclk; third flop needed for agreement check
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            sync3 <= 1'b0;
        end else begin
            sync1 <= comparator_raw;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end
    // polarity applied before the latch so edges follow the reported value
    always_comb begin
        polar = (sync2 ^ invert_bit) & on_bit;
        next_latched = latched;
        if (sync2 == sync3) begin
            next_latched = (sync3 ^ invert_bit) & on_bit;
        end
        if (!on_bit) begin
            next_latched = 1'b0;
        end
        rise = next_latched & ~latched;
        fall = ~next_latched & latched;
    end
    assign comparator_power = on_bit;
    // pin path skips the latch; routing to a pad is software's job
    assign pin_result = polar;

    // ----------------------------------------------------------------
    // input routing
    // ----------------------------------------------------------------
    always_comb begin
        negative_route = 6'h00;
        positive_route = 5'h00;
        if (on_bit) begin
            case (negative_channel_field)
                CCL_CH_GROUND: negative_route = 6'h20;
                CCL_CH_REF_BUF2: negative_route = 6'h10;
                3'h3: negative_route = 6'h08;
                3'h2: negative_route = 6'h04;
                3'h1: negative_route = 6'h02;
                3'h0: negative_route = 6'h01;
                default: negative_route = 6'h00;
            endcase
            case (positive_channel_field)
                CCL_CH_GROUND: positive_route = 5'h10;
                CCL_CH_REF_BUF2: positive_route = 5'h08;
                CCL_CH_CONVERTER: positive_route = 5'h04;
                CCL_CH_PIN1: positive_route = 5'h02;
                CCL_CH_PIN0: positive_route = 5'h01;
                default: positive_route = 5'h00;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // axi write channel and registers
    // ----------------------------------------------------------------
    always_comb begin
        s_axi_awready = ~aw_held;
        s_axi_wready = ~w_held;
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = s_axi_bvalid & ~s_axi_bready;
        next_bresp = s_axi_bresp;
        if (s_axi_awvalid && !aw_held) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_held) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        do_write = aw_held & w_held & ~s_axi_bvalid;
        write_ok = 1'b1;
        next_on_bit = on_bit;
        next_invert_bit = invert_bit;
        next_pos_edge_en = pos_edge_en;
        next_neg_edge_en = neg_edge_en;
        next_neg_field = negative_channel_field;
        next_pos_field = positive_channel_field;
        event_clear = 1'b0;
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            if (aw_addr == CCL_OFF_CONTROL_0) begin
                if (w_strb[0]) begin
                    next_on_bit = w_data[CCL_C0_ON];
                    next_invert_bit = w_data[CCL_C0_INVERT];
                end
            end else if (aw_addr == CCL_OFF_CONTROL_1) begin
                if (w_strb[0]) begin
                    next_pos_edge_en = w_data[CCL_C1_POS_EDGE];
                    next_neg_edge_en = w_data[CCL_C1_NEG_EDGE];
                end
            end else if (aw_addr == CCL_OFF_NEG_SEL) begin
                if (w_strb[0]) next_neg_field = w_data[2:0];
            end else if (aw_addr == CCL_OFF_POS_SEL) begin
                if (w_strb[0]) next_pos_field = w_data[2:0];
            end else if (aw_addr == CCL_OFF_EVENT) begin
                event_clear = w_strb[0] & ~w_data[0]; // write 0 clears
            end else if (aw_addr != CCL_OFF_MIRROR) begin
                write_ok = 1'b0;
            end
            next_bresp = write_ok ? CCL_RESP_OKAY : CCL_RESP_SLVERR;
        end
        // set wins over a same-cycle clear; enables gate only the edge kind
        next_event_flag = event_flag & ~event_clear;
        if ((rise && pos_edge_en) || (fall && neg_edge_en)) begin
            next_event_flag = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // axi read channel
    // ----------------------------------------------------------------
    always_comb begin
        s_axi_arready = ~s_axi_rvalid;
        rd_ok = 1'b1;
        rd_word = 32'h0000_0000;
        if (s_axi_araddr == CCL_OFF_CONTROL_0) begin
            rd_word[CCL_C0_ON] = on_bit;
            rd_word[CCL_C0_RESULT] = latched;
            rd_word[CCL_C0_INVERT] = invert_bit;
        end else if (s_axi_araddr == CCL_OFF_CONTROL_1) begin
            rd_word[CCL_C1_POS_EDGE] = pos_edge_en;
            rd_word[CCL_C1_NEG_EDGE] = neg_edge_en;
        end else if (s_axi_araddr == CCL_OFF_NEG_SEL) begin
            rd_word[2:0] = negative_channel_field;
        end else if (s_axi_araddr == CCL_OFF_POS_SEL) begin
            rd_word[2:0] = positive_channel_field;
        end else if (s_axi_araddr == CCL_OFF_MIRROR) begin
            rd_word[0] = latched;
        end else if (s_axi_araddr == CCL_OFF_EVENT) begin
            rd_word[0] = event_flag;
        end else begin
            rd_ok = 1'b0;
        end
        next_rvalid = s_axi_rvalid & ~s_axi_rready;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        if (s_axi_arvalid && !s_axi_rvalid) begin
            next_rvalid = 1'b1;
            next_rdata = rd_word;
            next_rresp = rd_ok ? CCL_RESP_OKAY : CCL_RESP_SLVERR;
        end
    end

    // register stage for all of the above
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            on_bit <= CCL_C0_RESET[CCL_C0_ON];
            invert_bit <= CCL_C0_RESET[CCL_C0_INVERT];
            pos_edge_en <= CCL_C1_RESET[CCL_C1_POS_EDGE];
            neg_edge_en <= CCL_C1_RESET[CCL_C1_NEG_EDGE];
            negative_channel_field <= CCL_SEL_RESET;
            positive_channel_field <= CCL_SEL_RESET;
            latched <= 1'b0;
            event_flag <= 1'b0;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= CCL_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= CCL_RESP_OKAY;
        end else begin
            on_bit <= next_on_bit;
            invert_bit <= next_invert_bit;
            pos_edge_en <= next_pos_edge_en;
            neg_edge_en <= next_neg_edge_en;
            negative_channel_field <= next_neg_field;
            positive_channel_field <= next_pos_field;
            latched <= next_latched;
            event_flag <= next_event_flag;
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_off_quiet;
        @(posedge aclk) disable iff (!aresetn)
        !on_bit |-> ((negative_route == 6'h00) && (positive_route == 5'h00)) ##1 !latched;
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("comparator active while off");
    property p_mirror;
        @(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && !s_axi_rvalid && s_axi_araddr == CCL_OFF_MIRROR) |=> s_axi_rdata[0] == $past(latched);
    endproperty
    a_mirror: assert property (p_mirror) else $error("mirror read wrong");
    property p_latch;
        @(posedge aclk) disable iff (!aresetn)
        (on_bit && sync2 == sync3 && $stable(on_bit)) |=> latched == $past(sync3 ^ invert_bit);
    endproperty
    a_latch: assert property (p_latch) else $error("latched result wrong");
    property p_polarity;
        @(posedge aclk) disable iff (!aresetn)
        on_bit |-> pin_result == (sync2 ^ invert_bit);
    endproperty
    a_polarity: assert property (p_polarity) else $error("pin polarity wrong");
    property p_neg_ground;
        @(posedge aclk) disable iff (!aresetn)
        (on_bit && negative_channel_field == 3'h7) |-> negative_route == 6'h20;
    endproperty
    a_neg_ground: assert property (p_neg_ground) else $error("negative ground route");
    property p_pos_conv;
        @(posedge aclk) disable iff (!aresetn)
        (on_bit && positive_channel_field == 3'h5) |-> positive_route == 5'h04;
    endproperty
    a_pos_conv: assert property (p_pos_conv) else $error("positive converter route");
    property p_sel_read;
        @(posedge aclk) disable iff (!aresetn)
        (s_axi_arvalid && !s_axi_rvalid && s_axi_araddr == CCL_OFF_NEG_SEL) |=> s_axi_rdata[31:3] == 29'h0;
    endproperty
    a_sel_read: assert property (p_sel_read) else $error("select upper bits not zero");
    property p_flag_hold;
        @(posedge aclk) disable iff (!aresetn)
        (event_flag && !event_clear) |=> event_flag;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("event flag dropped");
    property p_edge_set;
        @(posedge aclk) disable iff (!aresetn)
        (rise && pos_edge_en) |=> event_flag ##1 (event_flag || $past(event_clear));
    endproperty
    a_edge_set: assert property (p_edge_set) else $error("rising edge not flagged");
endmodule : ccl_comparator_control
`default_nettype wire

// ### logic/ccl_pkg.sv
// package for the comparator control block: register offsets, fields, reset values, mux codes
// assumes a 32-bit axi4-lite slave port, byte addresses word aligned
`default_nettype none
package ccl_pkg;
    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] CCL_OFF_CONTROL_0 = 8'h00;
    localparam logic [7:0] CCL_OFF_CONTROL_1 = 8'h04;
    localparam logic [7:0] CCL_OFF_NEG_SEL = 8'h08;
    localparam logic [7:0] CCL_OFF_POS_SEL = 8'h0C;
    localparam logic [7:0] CCL_OFF_MIRROR = 8'h10;
    localparam logic [7:0] CCL_OFF_EVENT = 8'h14;
    // ----------------------------------------------------------------
    // control 0 field positions
    // ----------------------------------------------------------------
    localparam int CCL_C0_ON = 7;
    localparam int CCL_C0_RESULT = 6;
    localparam int CCL_C0_INVERT = 4;
    // control 1 field positions
    localparam int CCL_C1_POS_EDGE = 1;
    localparam int CCL_C1_NEG_EDGE = 0;
    // select field width and reset values
    localparam int CCL_SEL_W = 3;
    localparam logic [2:0] CCL_SEL_RESET = 3'h0;
    localparam logic [7:0] CCL_C0_RESET = 8'h00;
    localparam logic [1:0] CCL_C1_RESET = 2'h0;
    // ----------------------------------------------------------------
    // channel codes
    // ----------------------------------------------------------------
    localparam logic [2:0] CCL_CH_GROUND = 3'h7;
    localparam logic [2:0] CCL_CH_REF_BUF2 = 3'h6;
    localparam logic [2:0] CCL_CH_CONVERTER = 3'h5;
    localparam logic [2:0] CCL_CH_PIN1 = 3'h1;
    localparam logic [2:0] CCL_CH_PIN0 = 3'h0;
    localparam logic [1:0] CCL_RESP_OKAY = 2'h0;
    localparam logic [1:0] CCL_RESP_SLVERR = 2'h2;
    // negative node route: one-hot over pin0..pin3, ref buffer 2, ground
    localparam int CCL_NROUTE_W = 6;
    // positive node route: pin0, pin1, converter, ref buffer 2, ground
    localparam int CCL_PROUTE_W = 5;
endpackage : ccl_pkg
`default_nettype wire

// ### sim/ccl_analog_model.sv
// analog partner: picks the node levels named by the routes and compares them
// assumes the bench drives node_levels as eight 8-bit node voltages
`default_nettype none
module ccl_analog_model (
    input wire logic aclk,
    input wire logic comparator_power,
    input wire logic [5:0] negative_route,
    input wire logic [4:0] positive_route,
    input wire logic [63:0] node_levels,
    output logic comparator_raw
);
    timeunit 1ns;
    timeprecision 100ps;
    logic flip = 1'b0;
    logic [7:0] vn;
    logic [7:0] vp;
    // open or unpowered inputs give a toggling answer, never a stable guess
    always @(posedge aclk) flip <= ~flip;
    // nodes: 0-3 negative pins, 4-5 positive pins, 6 converter, 7 ref buffer 2; ground reads 0
    always_comb begin
        vn = 8'h00;
        vp = 8'h00;
        for (int i = 0; i < 4; i++) if (negative_route[i]) vn = node_levels[8 * i +: 8];
        if (negative_route[4]) vn = node_levels[63:56];
        for (int j = 0; j < 4; j++) if (positive_route[j]) vp = node_levels[32 + 8 * j +: 8];
        if (!comparator_power || negative_route == 6'h00 || positive_route == 5'h00) comparator_raw = flip;
        else comparator_raw = vn < vp;
    end
endmodule : ccl_analog_model
`default_nettype wire

// ### sim/comparator_control_logic_tb_top.sv
// self-checking bench for the comparator control block: bus tasks, result queues, scenarios
// assumes ccl_pkg, the design and the analog partner model are compiled first
`default_nettype none
module comparator_control_logic_tb_top
    import ccl_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic aclk, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, comparator_raw, comparator_power, pin_result;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [5:0] negative_route;
    logic [4:0] positive_route;
    logic [63:0] node_levels = 64'h0;
    logic [1:0] exp_b[$];
    logic [33:0] exp_r[$];
    int fail_count = 0;
    int total_checks = 0;
    ccl_comparator_control DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .comparator_raw(comparator_raw), .comparator_power(comparator_power),
        .negative_route(negative_route), .positive_route(positive_route), .pin_result(pin_result));
    ccl_analog_model u_analog (.aclk(aclk), .comparator_power(comparator_power),
        .negative_route(negative_route), .positive_route(positive_route), .node_levels(node_levels),
        .comparator_raw(comparator_raw));
    // ----------------------------------------------------------------
    // clock, compare and verdict
    // ----------------------------------------------------------------
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expv);
        total_checks++;
        if (seen !== expv) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, expv, seen);
        end
    endtask : check
    task automatic finish_test();
        if (fail_count == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test
    // monitor: old values are seen at the edge, so a handshake is judged where it happens
    always @(posedge aclk) begin
        if (s_axi_bvalid && s_axi_bready) check("bresp", 32'(s_axi_bresp), 32'(exp_b.pop_front()));
        if (s_axi_rvalid && s_axi_rready) begin
            check("rresp", 32'(s_axi_rresp), 32'(exp_r[0][33:32]));
            check("rdata", s_axi_rdata, exp_r[0][31:0]);
            void'(exp_r.pop_front());
        end
    end
    // ----------------------------------------------------------------
    // bus tasks: enter just after an edge, leave one edge after the answer
    // ----------------------------------------------------------------
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        exp_b.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask : axi_write
    task automatic axi_read(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        exp_r.push_back({r, d});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask : axi_read
    // move positive pin 0, let the 3-4 cycle result path settle, then read the event flag
    task automatic step(input logic [7:0] lvl, input logic [31:0] evt);
        node_levels[39:32] <= lvl;
        repeat (8) @(posedge aclk);
        axi_read(CCL_OFF_EVENT, evt, CCL_RESP_OKAY);
    endtask : step
    function automatic logic [31:0] neg_hot(input int c);
        return (c < 4) ? (32'h1 << c) : (c == 6) ? 32'h10 : (c == 7) ? 32'h20 : 32'h0;
    endfunction : neg_hot
    function automatic logic [31:0] pos_hot(input int c);
        return (c < 2) ? (32'h1 << c) : (c > 4) ? (32'h1 << (c - 3)) : 32'h0;
    endfunction : pos_hot
    // watchdog: whole run needs under a thousand cycles
    initial begin
        repeat (20000) @(posedge aclk);
        fail_count++;
        finish_test();
    end
    // main sequence
    initial begin
        int n, p;
        logic inv, res;
        logic [7:0] va, vb;
        void'($urandom(57080));
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i < 6; i++) axi_read(8'(4 * i), 32'h0, CCL_RESP_OKAY);
        axi_write(8'h18, 32'hFF, CCL_RESP_SLVERR);
        axi_read(8'h18, 32'h0, CCL_RESP_SLVERR);
        axi_write(CCL_OFF_CONTROL_0, 32'h80, CCL_RESP_OKAY);
        check("power", 32'(comparator_power), 32'h1);
        for (int c = 0; c < 8; c++) begin
            axi_write(CCL_OFF_NEG_SEL, ($urandom() & 32'hFFFFFFF8) | c, CCL_RESP_OKAY);
            axi_write(CCL_OFF_POS_SEL, ($urandom() & 32'hFFFFFFF8) | c, CCL_RESP_OKAY);
            axi_read(CCL_OFF_NEG_SEL, c, CCL_RESP_OKAY);
            axi_read(CCL_OFF_POS_SEL, c, CCL_RESP_OKAY);
            check("negative_route", 32'(negative_route), neg_hot(c));
            check("positive_route", 32'(positive_route), pos_hot(c));
        end
        // reset in mid-run clears the selects and turns the comparator off
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi_read(CCL_OFF_NEG_SEL, 32'h0, CCL_RESP_OKAY);
        axi_read(CCL_OFF_POS_SEL, 32'h0, CCL_RESP_OKAY);
        check("power", 32'(comparator_power), 32'h0);
        check("negative_route", 32'(negative_route), 32'h0);
        // a write with byte lane 0 off must leave the select untouched
        s_axi_wstrb <= 4'hE;
        axi_write(CCL_OFF_NEG_SEL, 32'h5, CCL_RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        axi_read(CCL_OFF_NEG_SEL, 32'h0, CCL_RESP_OKAY);
        // random pins, levels and polarity
        for (int k = 0; k < 12; k++) begin
            n = $urandom_range(3, 0);
            p = $urandom_range(1, 0);
            inv = 1'($urandom_range(1, 0));
            va = 8'($urandom_range(120, 0));
            vb = va + 8'($urandom_range(100, 1));
            if ($urandom_range(1, 0) == 1) {va, vb} = {vb, va};
            node_levels[8 * n +: 8] <= va;
            node_levels[32 + 8 * p +: 8] <= vb;
            axi_write(CCL_OFF_CONTROL_0, 32'h80 | (32'(inv) << 4), CCL_RESP_OKAY);
            axi_write(CCL_OFF_NEG_SEL, 32'(n), CCL_RESP_OKAY);
            axi_write(CCL_OFF_POS_SEL, 32'(p), CCL_RESP_OKAY);
            repeat (8) @(posedge aclk);
            res = (va < vb) ^ inv;
            axi_read(CCL_OFF_CONTROL_0, 32'h80 | (32'(res) << 6) | (32'(inv) << 4), CCL_RESP_OKAY);
            axi_read(CCL_OFF_MIRROR, 32'(res), CCL_RESP_OKAY);
            check("pin_result", 32'(pin_result), 32'(res));
        end
        // edge events on negative pin 0 against positive pin 0
        axi_write(CCL_OFF_CONTROL_0, 32'h80, CCL_RESP_OKAY);
        axi_write(CCL_OFF_NEG_SEL, 32'h0, CCL_RESP_OKAY);
        axi_write(CCL_OFF_POS_SEL, 32'h0, CCL_RESP_OKAY);
        node_levels[7:0] <= 8'h32;
        step(8'h0A, 32'h0);
        axi_write(CCL_OFF_CONTROL_1, 32'h02, CCL_RESP_OKAY);
        axi_read(CCL_OFF_CONTROL_1, 32'h02, CCL_RESP_OKAY);
        step(8'h5A, 32'h1);
        axi_write(CCL_OFF_EVENT, 32'h1, CCL_RESP_OKAY);
        axi_read(CCL_OFF_EVENT, 32'h1, CCL_RESP_OKAY);
        axi_write(CCL_OFF_EVENT, 32'h0, CCL_RESP_OKAY);
        step(8'h0A, 32'h0);
        axi_write(CCL_OFF_CONTROL_1, 32'h01, CCL_RESP_OKAY);
        step(8'h5A, 32'h0);
        step(8'h0A, 32'h1);
        axi_write(CCL_OFF_EVENT, 32'h0, CCL_RESP_OKAY);
        step(8'h5A, 32'h0);
        // switching off from a high result drops it, which counts as a falling edge
        axi_write(CCL_OFF_CONTROL_0, 32'h0, CCL_RESP_OKAY);
        check("power", 32'(comparator_power), 32'h0);
        axi_read(CCL_OFF_CONTROL_0, 32'h0, CCL_RESP_OKAY);
        axi_read(CCL_OFF_EVENT, 32'h1, CCL_RESP_OKAY);
        axi_write(CCL_OFF_EVENT, 32'h0, CCL_RESP_OKAY);
        axi_read(CCL_OFF_EVENT, 32'h0, CCL_RESP_OKAY);
        finish_test();
    end
endmodule : comparator_control_logic_tb_top
`default_nettype wire
